// file: verilog/cpg_map.svh
`ifndef CPG_MAP_SVH
`define CPG_MAP_SVH

`define CPG_OFS_CTRL      8'h00
`define CPG_OFS_CMD       8'h04
`define CPG_OFS_PC        8'h08
`define CPG_OFS_SP        8'h0c
`define CPG_OFS_BANK      8'h10
`define CPG_OFS_STAT      8'h14
`define CPG_OFS_IRQ_STAT  8'h18
`define CPG_OFS_IRQ_CLR   8'h1c
`define CPG_OFS_IRQ_EN    8'h20

`define CPG_CTRL_EMU      0
`define CPG_STAT_BUSY     8
`define CPG_STAT_ABORT    9
`define CPG_STAT_PEND     10

`define CPG_IRQ_DONE      0
`define CPG_IRQ_ABORT     1
`define CPG_IRQ_W         2

`define CPG_RST_EMU       1'b1
`define CPG_RST_PC        16'h0000
`define CPG_RST_SP        16'h01ff
`define CPG_RST_BANK      8'h00

`define CPG_VEC_EMU       16'hfff8
`define CPG_VEC_NAT       16'hffe8
`define CPG_STACK_BANK    8'h00
`define CPG_EMU_SH        8'h01

`define CPG_PHI_HALF      2'd2

`endif

// file: verilog/cpg_pkg.sv
package cpg_pkg;

  typedef enum logic [2:0] {
    CPG_ST_IDLE = 3'b001,
    CPG_ST_LO   = 3'b010,
    CPG_ST_HI   = 3'b100
  } cpg_state_e;

  typedef enum logic [2:0] {
    CPG_OP_NONE  = 3'h0,
    CPG_OP_FETCH = 3'h1,
    CPG_OP_PUSH  = 3'h2,
    CPG_OP_PULL  = 3'h3,
    CPG_OP_READ  = 3'h4,
    CPG_OP_WRITE = 3'h5
  } cpg_op_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [4:0]  rsvd;
    cpg_op_e     op;
  } cpg_cmd_s;

  typedef struct packed {
    logic [7:0]  bank;
    logic [15:0] addr;
    logic        rnw;
    logic [7:0]  wdata;
  } cpg_cyc_s;

endpackage : cpg_pkg

// file: verilog/cpg_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpg_map.svh"
// Summary of operation
// - Program counter steps on every program fetch that is not aborted.
// - Stack pointer addresses every stack access.
// - Emulation forces stack high byte to one.
// - Stack cycles always use bank zero.
// - Abort request suppresses current instruction's updates.
// - Aborted instruction ends, then abort service starts.
// - Aborted opcode address is pushed as return.
// - Abort vector depends on emulation mode.
// - A low abort sample while a command runs, outside abort service, registers an abort.
// - Sixteen address lines, released when gate low.
// - Gate high drives address and direction.
// - Data lines driven first half, writes second.
// - Gate low disables all bus buffers.
// - Gate acts on enables without synchronisation.
// - Bank byte first half, data second half.
// - Direction high reads, low writes data.
module cpg_core
  import cpg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic        irq,
  output var  logic        emulation,
  output var  logic        phase_two_clock,
  output var  logic [15:0] address_lines,
  output logic             address_oe,
  output var  logic        read_not_write,
  output logic             read_not_write_oe,
  output var  logic [7:0]  data_bank_out,
  output logic             data_bank_oe,
  input  wire logic [7:0]  data_bank_in,
  input  wire logic        abort_request_n,
  input  wire logic        bus_output_gate
);

  function automatic logic [15:0] force_sp(input logic [15:0] v,
                                           input logic e);
    force_sp = e ? {`CPG_EMU_SH, v[7:0]} : v;
  endfunction : force_sp

  cpg_state_e             st;
  cpg_state_e             next_st;
  cpg_cmd_s               cmd;
  cpg_cyc_s               cyc;
  logic [1:0]             div_cnt;
  logic                   tick;
  logic                   phi_int;
  logic                   busy;
  logic                   in_abort;
  logic [1:0]             abort_step;
  logic                   abort_pend;
  logic                   abort_hit;
  logic                   abort_now;
  logic                   end_hi;
  logic                   seq_more;
  logic [15:0]            program_counter;
  logic [15:0]            stack_pointer;
  logic [15:0]            sp_eff;
  logic [15:0]            sp_inc;
  logic [15:0]            sp_dec;
  logic [15:0]            vec_base;
  logic [7:0]             vec_lo;
  logic [7:0]             rd_byte;
  logic [7:0]             prog_bank;
  logic [7:0]             data_bank;
  logic [`CPG_IRQ_W-1:0]  irq_stat;
  logic [`CPG_IRQ_W-1:0]  irq_en;
  logic [`CPG_IRQ_W-1:0]  irq_ev;
  logic [`CPG_IRQ_W-1:0]  irq_clr;
  logic                   drive_q;
  logic                   dben_q;
  logic                   addr_ok;
  logic                   wr_pend;
  logic [7:0]             wr_ofs;
  logic                   rd_pend;
  logic [7:0]             rd_ofs;
  logic [31:0]            rd_mux;
  logic                   wr_ctrl;
  logic                   wr_cmd;
  logic                   wr_pc;
  logic                   wr_sp;
  logic                   wr_bank;
  logic                   wr_clr;
  logic                   wr_en;
  logic                   cmd_done;
  logic                   abort_done;

  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_ctrl = wr_pend & (wr_ofs == `CPG_OFS_CTRL);
  assign wr_cmd  = wr_pend & (wr_ofs == `CPG_OFS_CMD);
  assign wr_pc   = wr_pend & (wr_ofs == `CPG_OFS_PC);
  assign wr_sp   = wr_pend & (wr_ofs == `CPG_OFS_SP);
  assign wr_bank = wr_pend & (wr_ofs == `CPG_OFS_BANK);
  assign wr_clr  = wr_pend & (wr_ofs == `CPG_OFS_IRQ_CLR);
  assign wr_en   = wr_pend & (wr_ofs == `CPG_OFS_IRQ_EN);

  // Phase two runs free; each half lasts CPG_PHI_HALF clocks.
  assign tick = (div_cnt == (`CPG_PHI_HALF - 2'd1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 2'd0;
    end else if (tick) begin
      div_cnt <= 2'd0;
    end else begin
      div_cnt <= div_cnt + 2'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phi_int         <= 1'b1;
      phase_two_clock <= 1'b1;
    end else begin
      if (tick) begin
        phi_int <= ~phi_int;
      end
      phase_two_clock <= phi_int;
    end
  end

  assign sp_eff   = force_sp(stack_pointer, emulation);
  assign sp_inc   = force_sp(stack_pointer + 16'h0001, emulation);
  assign sp_dec   = force_sp(stack_pointer - 16'h0001, emulation);
  assign vec_base = emulation ? `CPG_VEC_EMU : `CPG_VEC_NAT;

  always_comb begin
    cyc       = '0;
    cyc.rnw   = 1'b1;
    if (in_abort) begin
      case (abort_step)
        2'd0: begin
          cyc.bank  = `CPG_STACK_BANK;
          cyc.addr  = sp_eff;
          cyc.rnw   = 1'b0;
          cyc.wdata = program_counter[15:8];
        end
        2'd1: begin
          cyc.bank  = `CPG_STACK_BANK;
          cyc.addr  = sp_eff;
          cyc.rnw   = 1'b0;
          cyc.wdata = program_counter[7:0];
        end
        2'd2: begin
          cyc.bank = 8'h00;
          cyc.addr = vec_base;
        end
        default: begin
          cyc.bank = 8'h00;
          cyc.addr = {vec_base[15:1], 1'b1};
        end
      endcase
    end else begin
      case (cmd.op)
        CPG_OP_FETCH: begin
          cyc.bank = prog_bank;
          cyc.addr = program_counter;
        end
        CPG_OP_PUSH: begin
          cyc.bank  = `CPG_STACK_BANK;
          cyc.addr  = sp_eff;
          cyc.rnw   = 1'b0;
          cyc.wdata = cmd.wdata;
        end
        CPG_OP_PULL: begin
          cyc.bank = `CPG_STACK_BANK;
          cyc.addr = sp_inc;
        end
        CPG_OP_READ: begin
          cyc.bank = data_bank;
          cyc.addr = cmd.addr;
        end
        CPG_OP_WRITE: begin
          cyc.bank  = data_bank;
          cyc.addr  = cmd.addr;
          cyc.rnw   = 1'b0;
          cyc.wdata = cmd.wdata;
        end
        default: begin
          cyc.bank = prog_bank;
        end
      endcase
    end
  end

  // Abort input is level and pulse sensitive: any low sample counts while busy and not in abort service.
  assign abort_hit = ~abort_request_n & busy & ~in_abort;
  assign abort_now = abort_pend | abort_hit;
  assign end_hi    = tick & (st == CPG_ST_HI);
  assign seq_more  = in_abort ? (abort_step != 2'd3) : abort_now;
  assign cmd_done  = end_hi & ~in_abort & ~abort_now;
  assign abort_done = end_hi & in_abort & (abort_step == 2'd3);

  always_comb begin
    next_st = st;
    case (st)
      CPG_ST_IDLE: begin
        if (tick & phi_int & busy) begin
          next_st = CPG_ST_LO;
        end
      end
      CPG_ST_LO: begin
        if (tick) begin
          next_st = CPG_ST_HI;
        end
      end
      CPG_ST_HI: begin
        if (tick) begin
          next_st = seq_more ? CPG_ST_LO : CPG_ST_IDLE;
        end
      end
      default: begin
        next_st = CPG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= CPG_ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy       <= 1'b0;
      cmd        <= '0;
      in_abort   <= 1'b0;
      abort_step <= 2'd0;
      abort_pend <= 1'b0;
    end else begin
      if (wr_cmd & ~busy) begin
        cmd  <= cpg_cmd_s'(hwdata);
        busy <= (cpg_op_e'(hwdata[2:0]) inside {CPG_OP_FETCH, CPG_OP_PUSH,
                 CPG_OP_PULL, CPG_OP_READ, CPG_OP_WRITE});
      end
      if (end_hi) begin
        abort_pend <= 1'b0;
      end else if (abort_hit) begin
        abort_pend <= 1'b1;
      end
      if (end_hi & ~in_abort) begin
        if (abort_now) begin
          in_abort   <= 1'b1;
          abort_step <= 2'd0;
        end else begin
          busy <= 1'b0;
        end
      end else if (end_hi & in_abort) begin
        abort_step <= abort_step + 2'd1;
        if (abort_step == 2'd3) begin
          in_abort <= 1'b0;
          busy     <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_counter <= `CPG_RST_PC;
    end else if (abort_done) begin
      program_counter <= {data_bank_in, vec_lo};
    end else if (cmd_done & (cmd.op == CPG_OP_FETCH)) begin
      program_counter <= program_counter + 16'h0001;
    end else if (wr_pc) begin
      program_counter <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_pointer <= `CPG_RST_SP;
    end else if (end_hi & in_abort & (abort_step[1] == 1'b0)) begin
      stack_pointer <= sp_dec;
    end else if (cmd_done & (cmd.op == CPG_OP_PUSH)) begin
      stack_pointer <= sp_dec;
    end else if (cmd_done & (cmd.op == CPG_OP_PULL)) begin
      stack_pointer <= sp_inc;
    end else if (wr_sp) begin
      stack_pointer <= force_sp(hwdata[15:0], emulation);
    end else begin
      stack_pointer <= sp_eff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_byte <= 8'h00;
      vec_lo  <= 8'h00;
    end else begin
      if (end_hi & in_abort & (abort_step == 2'd2)) begin
        vec_lo <= data_bank_in;
      end
      if (cmd_done & cyc.rnw) begin
        rd_byte <= data_bank_in;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emulation <= `CPG_RST_EMU;
      prog_bank <= `CPG_RST_BANK;
      data_bank <= `CPG_RST_BANK;
      irq_en    <= '0;
    end else begin
      if (wr_ctrl) begin
        emulation <= hwdata[`CPG_CTRL_EMU];
      end
      if (wr_bank) begin
        prog_bank <= hwdata[7:0];
        data_bank <= hwdata[15:8];
      end
      if (wr_en) begin
        irq_en <= hwdata[`CPG_IRQ_W-1:0];
      end
    end
  end

  assign irq_ev[`CPG_IRQ_DONE]  = cmd_done;
  assign irq_ev[`CPG_IRQ_ABORT] = abort_done;
  assign irq_clr = wr_clr ? hwdata[`CPG_IRQ_W-1:0] : '0;

  // A new event wins over a clear landing in the same cycle.
  for (genvar i = 0; i < `CPG_IRQ_W; i++) begin : g_irq
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        irq_stat[i] <= 1'b0;
      end else if (irq_ev[i]) begin
        irq_stat[i] <= 1'b1;
      end else if (irq_clr[i]) begin
        irq_stat[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  // Pins follow the state one clock late, aligned with phase_two_clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      address_lines  <= 16'h0000;
      read_not_write <= 1'b1;
      data_bank_out  <= 8'h00;
      dben_q         <= 1'b0;
      drive_q        <= 1'b0;
    end else begin
      drive_q <= 1'b1;
      case (st)
        CPG_ST_LO: begin
          address_lines  <= cyc.addr;
          read_not_write <= cyc.rnw;
          data_bank_out  <= cyc.bank;
          dben_q         <= 1'b1;
        end
        CPG_ST_HI: begin
          data_bank_out <= cyc.wdata;
          dben_q        <= ~cyc.rnw;
        end
        default: begin
          read_not_write <= 1'b1;
          dben_q         <= 1'b0;
        end
      endcase
    end
  end

  // Bus gate is not synchronised so the buffers follow it directly.
  assign address_oe        = bus_output_gate & drive_q;
  assign read_not_write_oe = bus_output_gate & drive_q;
  assign data_bank_oe      = bus_output_gate & dben_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_ofs)
      `CPG_OFS_CTRL:     rd_mux[`CPG_CTRL_EMU] = emulation;
      `CPG_OFS_PC:       rd_mux[15:0] = program_counter;
      `CPG_OFS_SP:       rd_mux[15:0] = sp_eff;
      `CPG_OFS_BANK:     rd_mux[15:0] = {data_bank, prog_bank};
      `CPG_OFS_STAT: begin
        rd_mux[7:0]             = rd_byte;
        rd_mux[`CPG_STAT_BUSY]  = busy;
        rd_mux[`CPG_STAT_ABORT] = in_abort;
        rd_mux[`CPG_STAT_PEND]  = abort_pend;
      end
      `CPG_OFS_IRQ_STAT: rd_mux[`CPG_IRQ_W-1:0] = irq_stat;
      `CPG_OFS_IRQ_EN:   rd_mux[`CPG_IRQ_W-1:0] = irq_en;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Writes complete with no wait; reads take one wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_ofs    <= 8'h00;
      rd_pend   <= 1'b0;
      rd_ofs    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp   <= 1'b0;
      wr_pend <= addr_ok & hwrite;
      if (addr_ok & hwrite) begin
        wr_ofs <= haddr[7:0];
      end
      if (addr_ok & ~hwrite) begin
        rd_pend   <= 1'b1;
        rd_ofs    <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= rd_mux;
    end
  end

endmodule : cpg_core
`default_nettype wire

// file: dv/cpg_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cpg_core_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        phase_two_clock,
  input wire logic [15:0] address_lines,
  input wire logic        address_oe,
  input wire logic        read_not_write,
  input wire logic        read_not_write_oe,
  input wire logic [7:0]  data_bank_out,
  input wire logic        data_bank_oe,
  input wire logic        bus_output_gate
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence phi_rest;
    phase_two_clock ##1 !phase_two_clock [*2] ##1 phase_two_clock;
  endsequence
  chk_gate_off: assert property (
    !bus_output_gate |-> !address_oe && !read_not_write_oe && !data_bank_oe)
    else $error("bus driven while gate low");
  chk_oe_pair: assert property (
    address_oe == read_not_write_oe) else $error("enables differ");
  chk_gate_on: assert property (
    $past(hresetn) && bus_output_gate |-> address_oe)
    else $error("address not driven with gate high");
  chk_data_half: assert property (
    data_bank_oe && phase_two_clock |-> !read_not_write)
    else $error("data lines driven in read high half");
  chk_write_drive: assert property (
    !read_not_write && bus_output_gate |-> data_bank_oe)
    else $error("write data not driven");
  chk_addr_hold: assert property (
    $rose(phase_two_clock) |-> $stable(address_lines) && $stable(read_not_write))
    else $error("address moved inside cycle");
  chk_wdata_hold: assert property (
    phase_two_clock && $past(phase_two_clock) && !read_not_write
      |-> $stable(data_bank_out)) else $error("write byte moved");
  chk_read_wait: assert property (
    hsel && htrans[1] && !hwrite && hready |=> rd_wait)
    else $error("read answer timing wrong");
  chk_resp_okay: assert property (
    hresp == 1'b0) else $error("response not okay");
  chk_phi_shape: assert property (
    $rose(phase_two_clock) |-> ##1 phi_rest) else $error("phase shape wrong");
endmodule : cpg_core_chk
bind cpg_core cpg_core_chk cpg_core_chk_i (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .phase_two_clock, .address_lines,
  .address_oe, .read_not_write, .read_not_write_oe, .data_bank_out,
  .data_bank_oe, .bus_output_gate);
`default_nettype wire

// file: dv/cpg_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpg_mem_model (
  input  wire logic        hclk,
  input  wire logic        phase_two_clock,
  input  wire logic [15:0] address_lines,
  input  wire logic        address_oe,
  input  wire logic        read_not_write,
  input  wire logic [7:0]  data_bank_out,
  input  wire logic        data_bank_oe,
  output var  logic [7:0]  data_bank_in,
  output var  logic [7:0]  wr_bank
);
  logic [7:0] mem [0:65535];
  logic [7:0] bank_q = 8'h00;
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
  end
  // A released line shows the inverse of its last level, never a held value.
  always_comb begin
    if (data_bank_oe)
      data_bank_in = data_bank_out;
    else if (phase_two_clock && read_not_write && address_oe)
      data_bank_in = mem[address_lines];
    else
      data_bank_in = ~last;
  end
  always @(posedge hclk) begin
    last <= data_bank_in;
    if (!phase_two_clock && data_bank_oe)
      bank_q <= data_bank_out;
    if (phase_two_clock && data_bank_oe && !read_not_write) begin
      mem[address_lines] <= data_bank_out;
      wr_bank <= bank_q;
    end
  end
endmodule : cpg_mem_model
`default_nettype wire

// file: dv/cpg_pc_stack_abort_bus_gate_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpg_map.svh"
module cpg_pc_stack_abort_bus_gate_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        abort_request_n = 1'b1;
  logic        bus_output_gate = 1'b1;
  logic        rd_ph = 1'b0;
  logic [31:0] seed = 32'ha8d9;
  logic [15:0] v;
  logic [31:0] exp_q [$];
  int          mismatches = 0;
  int          total_checks = 0;
  wire  [31:0] hrdata;
  wire  [15:0] address_lines;
  wire  [7:0]  data_bank_out, data_bank_in, wr_bank;
  wire         hreadyout, hresp, irq, phase_two_clock, address_oe, emulation;
  wire         read_not_write, read_not_write_oe, data_bank_oe;

  cpg_core cpg_core_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .irq, .emulation, .phase_two_clock, .address_lines, .address_oe,
    .read_not_write, .read_not_write_oe, .data_bank_out, .data_bank_oe,
    .data_bank_in, .abort_request_n, .bus_output_gate);
  cpg_mem_model cpg_mem_model_i (.hclk, .phase_two_clock, .address_lines,
    .address_oe, .read_not_write, .data_bank_out, .data_bank_oe,
    .data_bank_in, .wr_bank);

  initial begin
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : pat

  task automatic compare(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : compare

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    ahb(1'b0, a, 32'h0);
  endtask : rd

  // Each read result is matched against the oldest expectation.
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1)
      compare("register read", exp_q.pop_front(), hrdata);
  end

  task automatic cmd(input logic [2:0] op, input logic [7:0] b,
                     input logic [15:0] a);
    wr(`CPG_OFS_CMD, {a, b, 5'h0, op});
    for (int n = 0; n < 300 && irq !== 1'b1; n++)
      @(posedge hclk);
    compare("command irq", 32'h1, {31'h0, irq});
  endtask : cmd

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`CPG_OFS_CTRL, 32'h1);
    compare("emulation pin", 32'h1, {31'h0, emulation});
    rd(`CPG_OFS_PC, 32'h0);
    rd(`CPG_OFS_SP, 32'h1ff);
    rd(`CPG_OFS_IRQ_EN, 32'h0);
    rd(8'h40, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(`CPG_OFS_SP, seed);
      rd(`CPG_OFS_SP, {16'h0, 8'h01, seed[7:0]});
    end
    wr(`CPG_OFS_CTRL, 32'h0);
    wr(`CPG_OFS_SP, seed);
    rd(`CPG_OFS_SP, {16'h0, seed[15:0]});
    compare("emulation pin", 32'h0, {31'h0, emulation});
    $display("test stack high byte done");
    wr(`CPG_OFS_IRQ_EN, 32'h3);
    wr(`CPG_OFS_BANK, 32'hc3a5);
    wr(`CPG_OFS_PC, 32'hffff);
    cmd(3'h1, 8'h0, 16'h0);
    rd(`CPG_OFS_PC, 32'h0);
    rd(`CPG_OFS_STAT, {24'h0, pat(16'hffff)});
    rd(`CPG_OFS_IRQ_STAT, 32'h1);
    wr(`CPG_OFS_IRQ_CLR, 32'h3);
    $display("test fetch done");
    seed = xs(seed);
    wr(`CPG_OFS_SP, 32'h8000);
    cmd(3'h2, seed[7:0], 16'h0);
    wr(`CPG_OFS_IRQ_CLR, 32'h3);
    rd(`CPG_OFS_SP, 32'h7fff);
    compare("pushed byte", {24'h0, seed[7:0]}, cpg_mem_model_i.mem[16'h8000]);
    compare("stack bank", 32'h0, {24'h0, wr_bank});
    cmd(3'h3, 8'h0, 16'h0);
    wr(`CPG_OFS_IRQ_CLR, 32'h3);
    rd(`CPG_OFS_SP, 32'h8000);
    rd(`CPG_OFS_STAT, {24'h0, seed[7:0]});
    cmd(3'h5, ~seed[7:0], 16'h0400);
    wr(`CPG_OFS_IRQ_CLR, 32'h3);
    compare("data bank", 32'hc3, {24'h0, wr_bank});
    compare("written byte", {24'h0, ~seed[7:0]}, cpg_mem_model_i.mem[16'h0400]);
    cmd(3'h4, 8'h0, 16'h0400);
    wr(`CPG_OFS_IRQ_CLR, 32'h3);
    rd(`CPG_OFS_STAT, {24'h0, ~seed[7:0]});
    $display("test stack and data done");
    bus_output_gate <= 1'b0;
    #1;
    compare("address enable", 32'h0, {31'h0, address_oe});
    @(posedge hclk);
    wr(`CPG_OFS_CMD, {16'h0400, 8'h0, 5'h0, 3'h4});
    for (int n = 0; n < 40; n++) begin
      seed = xs(seed);
      bus_output_gate <= seed[0];
      @(posedge hclk);
    end
    bus_output_gate <= 1'b1;
    rd(`CPG_OFS_IRQ_STAT, 32'h1);
    wr(`CPG_OFS_IRQ_CLR, 32'h3);
    $display("test bus gate done");
    for (int m = 0; m < 2; m++) begin
      wr(`CPG_OFS_CTRL, m);
      wr(`CPG_OFS_SP, 32'h01f0);
      wr(`CPG_OFS_PC, 32'h2345);
      wr(`CPG_OFS_CMD, 32'h1);
      abort_request_n <= 1'b0;
      repeat (m + 1) @(posedge hclk);
      abort_request_n <= 1'b1;
      for (int n = 0; n < 300 && irq !== 1'b1; n++)
        @(posedge hclk);
      compare("abort irq", 32'h1, {31'h0, irq});
      v = m ? 16'hfff8 : 16'hffe8;
      rd(`CPG_OFS_PC, {16'h0, pat(v + 16'h1), pat(v)});
      rd(`CPG_OFS_SP, 32'h01ee);
      rd(`CPG_OFS_IRQ_STAT, 32'h2);
      compare("return high", 32'h23, cpg_mem_model_i.mem[16'h01f0]);
      compare("return low", 32'h45, cpg_mem_model_i.mem[16'h01ef]);
      wr(`CPG_OFS_IRQ_CLR, 32'h3);
    end
    $display("test abort done");
    give_verdict;
  end

  // The whole sequence needs a few hundred cycles; allow ten thousand.
  initial begin
    #400000;
    mismatches++;
    $display("watchdog expired");
    give_verdict;
  end
endmodule : cpg_pc_stack_abort_bus_gate_tb
`default_nettype wire
